// ### design/csf_core.sv
// Summary of operation
// - Flags refreshed after every ALU operation.
// - Status not saved or restored on interrupts.
// - Bit 7 clear blocks every interrupt.
// - Taking interrupt clears bit 7; return sets.
// - Set and clear instructions drive bit 7.
// - Bit 6 stores and loads copied bits.
// - Bit 5 holds low-nibble half carry.
// - Bit 4 always equals N xor V.
// - Bit 3 holds signed overflow.
// - Bit 2 holds result sign bit.
// - Bit 1 set on zero result.
// - Bit 0 holds carry or borrow.
// - Next instruction prefetched while current executes.
// - Thirty-two registers, two reads, one write.
// - Three register pairs act as pointers.
// - Sixty-four I/O addresses, also at 0x20-0x5F.
// - Lowest pending vector wins.
// - ALU operations finish in one cycle.
`timescale 1ns/1ps
`include "csf_map.svh"

module csf_core
    import csf_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    output logic [15:0] pm_addr_o,
    input wire csf_instr_t pm_data_i,
    output logic [15:0] tbl_addr_o,
    input wire logic [7:0] tbl_data_i,
    output logic [5:0] io_addr_o,
    output logic [7:0] io_wdata_o,
    output logic io_we_o,
    output logic io_re_o,
    input wire logic [7:0] io_rdata_i,
    input wire logic [7:0] irq_req_i,
    output logic irq_ack_o,
    output logic [2:0] irq_id_o,
    input wire logic [6:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o
);

    // Sum or difference with flags, shared by all add and subtract forms except INC and DEC.
    function automatic csf_alu_t arith(input logic [7:0] a, input logic [7:0] b,
                                       input logic cin, input logic sub);
        csf_alu_t r;
        logic [8:0] w;
        r = '0;
        if (sub)
        begin
            w = {1'b0, a} - {1'b0, b} - {8'h00, cin};
        end
        else
        begin
            w = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        end
        r.res = w[7:0];
        if (sub)
        begin
            r.h = (~a[3] & b[3]) | (b[3] & r.res[3]) | (r.res[3] & ~a[3]);
            r.v = (a[7] & ~b[7] & ~r.res[7]) | (~a[7] & b[7] & r.res[7]);
        end
        else
        begin
            r.h = (a[3] & b[3]) | (b[3] & ~r.res[3]) | (~r.res[3] & a[3]);
            r.v = (a[7] & b[7] & ~r.res[7]) | (~a[7] & ~b[7] & r.res[7]);
        end
        r.c = w[8];
        r.n = r.res[7];
        r.z = (r.res == 8'h00);
        r.wmask = 5'h1F;
        r.wr_reg = 1'b1;
        return r;
    endfunction

    // Logic result: overflow cleared, carry and half carry untouched.
    function automatic csf_alu_t logic_res(input logic [7:0] v);
        csf_alu_t r;
        r = '0;
        r.res = v;
        r.n = v[7];
        r.z = (v == 8'h00);
        r.wmask = 5'h0E;
        r.wr_reg = 1'b1;
        return r;
    endfunction

    logic [7:0] regs [`CSF_NUM_REGS];
    logic [7:0] status;
    logic [15:0] pc;
    logic [15:0] fetch_pc;
    csf_instr_t instr_q;
    logic valid_q;
    logic irq_hold;
    logic [15:0] ret_stack [`CSF_RET_DEPTH];
    logic [2:0] ret_depth;
    logic [7:0] op_a;
    logic [7:0] op_b;
    logic [15:0] ptr;
    logic [15:0] next_pc;
    logic ptr_is_reg;
    logic ptr_is_io;
    logic [5:0] io_sel;
    logic io_acc;
    logic io_is_status;
    logic [7:0] io_rd_val;
    logic take_irq;
    logic [2:0] irq_win;
    logic any_irq;
    csf_alu_t alu;
    logic [4:0] wr_idx;
    logic stat_wr;
    logic [7:0] stat_wval;
    logic exec;

    // Two operands come straight out of the file in the execute cycle.
    // dual operand read
    assign op_a = regs[instr_q.rd];
    assign op_b = regs[instr_q.rr];

    always_comb
    begin
        unique case (instr_q.rr[1:0])
            2'h0: ptr = {regs[`CSF_PTR_X + 5'h01], regs[`CSF_PTR_X]};
            2'h1: ptr = {regs[`CSF_PTR_Y + 5'h01], regs[`CSF_PTR_Y]};
            default: ptr = {regs[`CSF_PTR_Z + 5'h01], regs[`CSF_PTR_Z]};
        endcase
    end

    assign tbl_addr_o = {regs[`CSF_PTR_Z + 5'h01], regs[`CSF_PTR_Z]};

    always_comb
    begin
        irq_win = 3'h0;
        any_irq = 1'b0;
        for (int i = `CSF_NUM_IRQ - 1; i >= 0; i--)
        begin
            if (irq_req_i[i])
            begin
                irq_win = i[2:0];
                any_irq = 1'b1;
            end
        end
    end

    // One instruction always runs after a return before the next interrupt,
    // so a steady request cannot starve the interrupted program.
    // global enable gate
    assign take_irq = valid_q && any_irq && status[`CSF_BIT_I] && !irq_hold &&
                      (ret_depth != 3'(`CSF_RET_DEPTH));
    assign exec = valid_q && !take_irq;
    assign irq_ack_o = take_irq;
    assign irq_id_o = irq_win;

    assign ptr_is_reg = (ptr < 16'(`CSF_NUM_REGS));
    assign ptr_is_io = (ptr >= `CSF_IO_BASE) && (ptr <= `CSF_IO_LAST);
    always_comb
    begin
        io_sel = instr_q.imm[5:0];
        io_acc = 1'b0;
        if (instr_q.op == OP_IN || instr_q.op == OP_OUT)
        begin
            io_acc = 1'b1;
        end
        else if ((instr_q.op == OP_LDP || instr_q.op == OP_STP) && ptr_is_io)
        begin
            io_sel = 6'(ptr - `CSF_IO_BASE);
            io_acc = 1'b1;
        end
    end
    assign io_is_status = (io_sel == `CSF_IO_STATUS);
    assign io_addr_o = io_sel;
    assign io_we_o = exec && io_acc && !io_is_status &&
                     (instr_q.op == OP_OUT || instr_q.op == OP_STP);
    assign io_re_o = exec && io_acc && !io_is_status &&
                     (instr_q.op == OP_IN || instr_q.op == OP_LDP);
    assign io_wdata_o = op_a;
    assign io_rd_val = io_is_status ? status : io_rdata_i;

    // Single-cycle ALU and move decode.
    // one-cycle ALU
    always_comb
    begin
        alu = '0;
        unique case (instr_q.op)
            OP_ADD: alu = arith(op_a, op_b, 1'b0, 1'b0);
            OP_ADC: alu = arith(op_a, op_b, status[`CSF_BIT_C], 1'b0);
            OP_SUB: alu = arith(op_a, op_b, 1'b0, 1'b1);
            OP_SUBI: alu = arith(op_a, instr_q.imm, 1'b0, 1'b1);
            OP_SBC, OP_SBCI:
            begin
                alu = arith(op_a, (instr_q.op == OP_SBC) ? op_b : instr_q.imm,
                            status[`CSF_BIT_C], 1'b1);
                // Zero only survives a chain of all-zero bytes.
                alu.z = alu.z & status[`CSF_BIT_Z];
            end
            OP_AND: alu = logic_res(op_a & op_b);
            OP_ANDI: alu = logic_res(op_a & instr_q.imm);
            OP_OR: alu = logic_res(op_a | op_b);
            OP_ORI: alu = logic_res(op_a | instr_q.imm);
            OP_EOR: alu = logic_res(op_a ^ op_b);
            OP_COM:
            begin
                alu = logic_res(~op_a);
                alu.c = 1'b1;
                alu.wmask = 5'h0F;
            end
            OP_NEG: alu = arith(8'h00, op_a, 1'b0, 1'b1);
            OP_INC:
            begin
                alu = logic_res(op_a + 8'h01);
                alu.v = (op_a == 8'h7F);
            end
            OP_DEC:
            begin
                alu = logic_res(op_a - 8'h01);
                alu.v = (op_a == 8'h80);
            end
            OP_LSR, OP_ROR:
            begin
                alu = logic_res({(instr_q.op == OP_ROR) & status[`CSF_BIT_C], op_a[7:1]});
                alu.c = op_a[0];
                alu.v = alu.n ^ alu.c;
                alu.wmask = 5'h0F;
            end
            OP_MOV:
            begin
                alu.res = op_b;
                alu.wr_reg = 1'b1;
            end
            OP_LDI:
            begin
                alu.res = instr_q.imm;
                alu.wr_reg = 1'b1;
            end
            OP_BLD:
            begin
                alu.res = op_a;
                alu.res[instr_q.bsel] = status[`CSF_BIT_T];
                alu.wr_reg = 1'b1;
            end
            OP_LPM:
            begin
                alu.res = tbl_data_i;
                alu.wr_reg = 1'b1;
            end
            OP_IN:
            begin
                alu.res = io_rd_val;
                alu.wr_reg = 1'b1;
            end
            OP_LDP:
            begin
                alu.res = ptr_is_reg ? regs[ptr[4:0]] : (ptr_is_io ? io_rd_val : 8'h00);
                alu.wr_reg = 1'b1;
            end
            default: alu = '0;
        endcase
    end

    // Destination of a register write; pointer stores may land in the file.
    assign wr_idx = (instr_q.op == OP_STP) ? ptr[4:0] : instr_q.rd;

    // Register file: core writes win over a same-cycle port write.
    // single result write
    always_ff @(posedge clk_i)
    begin
        if (reg_wr_i && reg_addr_i <= `CSF_ADDR_REG_LAST)
        begin
            regs[reg_addr_i[4:0]] <= reg_wdata_i;
        end
        if (exec && alu.wr_reg)
        begin
            regs[wr_idx] <= alu.res;
        end
        else if (exec && instr_q.op == OP_STP && ptr_is_reg)
        begin
            regs[wr_idx] <= op_a;
        end
    end

    // Software writes to the status byte over the I/O space or port.
    assign stat_wr = (exec && io_acc && io_is_status &&
                      (instr_q.op == OP_OUT || instr_q.op == OP_STP)) ||
                     (reg_wr_i && reg_addr_i == `CSF_ADDR_STATUS);
    assign stat_wval = (reg_wr_i && reg_addr_i == `CSF_ADDR_STATUS) ? reg_wdata_i : op_a;

    // Status flags. Bit 4 is never stored apart: it is rebuilt from N and V
    // on every update so no write path can leave it inconsistent.
    // no save or restore
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            status <= `CSF_STATUS_RESET;
        end
        else
        begin
            logic [7:0] s;
            s = stat_wr ? stat_wval : status;
            if (exec)
            begin
                if (alu.wmask[4]) s[`CSF_BIT_H] = alu.h;
                if (alu.wmask[3]) s[`CSF_BIT_V] = alu.v;
                if (alu.wmask[2]) s[`CSF_BIT_N] = alu.n;
                if (alu.wmask[1]) s[`CSF_BIT_Z] = alu.z;
                if (alu.wmask[0]) s[`CSF_BIT_C] = alu.c;
                if (instr_q.op == OP_BST) s[`CSF_BIT_T] = op_a[instr_q.bsel];
                if (instr_q.op == OP_SEI) s[`CSF_BIT_I] = 1'b1;
                if (instr_q.op == OP_CLI) s[`CSF_BIT_I] = 1'b0;
                if (instr_q.op == OP_IRQ_RETURN_INSTR) s[`CSF_BIT_I] = 1'b1;
            end
            if (take_irq) s[`CSF_BIT_I] = 1'b0;
            s[`CSF_BIT_S] = s[`CSF_BIT_N] ^ s[`CSF_BIT_V];
            status <= s;
        end
    end

    // Next fetch address: vector, return, relative jump or sequential.
    always_comb
    begin
        next_pc = pc + 16'h0001;
        if (take_irq)
        begin
            next_pc = `CSF_VEC_STRIDE * {12'h000, {1'b0, irq_win} + 4'h1};
        end
        else if (exec && instr_q.op == OP_IRQ_RETURN_INSTR && ret_depth != 3'h0)
        begin
            next_pc = ret_stack[ret_depth[1:0] - 2'h1];
        end
        else if (exec && instr_q.op == OP_RJMP)
        begin
            next_pc = fetch_pc + 16'h0001 + {{8{instr_q.imm[7]}}, instr_q.imm};
        end
    end

    // Prefetch stage: the word at pc is latched while instr_q executes.
    // A redirect drops the prefetched word, costing one bubble.
    // one-stage prefetch
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pc <= `CSF_RESET_PC;
            fetch_pc <= `CSF_RESET_PC;
            valid_q <= 1'b0;
            instr_q <= '0;
        end
        else
        begin
            pc <= next_pc;
            fetch_pc <= pc;
            instr_q <= pm_data_i;
            // Decided by the redirect itself, since a jump target may equal pc + 1.
            valid_q <= !(take_irq || (exec && instr_q.op == OP_RJMP) ||
                         (exec && instr_q.op == OP_IRQ_RETURN_INSTR && ret_depth != 3'h0));
        end
    end
    assign pm_addr_o = pc;

    // Return addresses; nesting beyond the depth defers new interrupts.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ret_depth <= 3'h0;
        end
        else if (take_irq)
        begin
            ret_stack[ret_depth[1:0]] <= fetch_pc;
            ret_depth <= ret_depth + 3'h1;
        end
        else if (exec && instr_q.op == OP_IRQ_RETURN_INSTR && ret_depth != 3'h0)
        begin
            ret_depth <= ret_depth - 3'h1;
        end
    end

    // Hold interrupts from a return until one instruction has executed.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            irq_hold <= 1'b0;
        end
        else if (exec && instr_q.op == OP_IRQ_RETURN_INSTR)
        begin
            irq_hold <= 1'b1;
        end
        else if (exec)
        begin
            irq_hold <= 1'b0;
        end
    end

    // Register port read: data stands in the cycle after the strobe.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            reg_rdata_o <= 8'h00;
        end
        else if (reg_rd_i)
        begin
            if (reg_addr_i <= `CSF_ADDR_REG_LAST)
            begin
                reg_rdata_o <= regs[reg_addr_i[4:0]];
            end
            else if (reg_addr_i == `CSF_ADDR_STATUS)
            begin
                reg_rdata_o <= status;
            end
            else if (reg_addr_i == `CSF_ADDR_CORE_STATE)
            begin
                reg_rdata_o <= {any_irq, irq_hold, valid_q, 2'b00, ret_depth};
            end
            else
            begin
                reg_rdata_o <= 8'h00;
            end
        end
        else
        begin
            reg_rdata_o <= 8'h00;
        end
    end

endmodule

// ### design/csf_map.svh
`ifndef CSF_MAP_SVH
`define CSF_MAP_SVH

// Status flag bit positions.
`define CSF_BIT_I 7
`define CSF_BIT_T 6
`define CSF_BIT_H 5
`define CSF_BIT_S 4
`define CSF_BIT_V 3
`define CSF_BIT_N 2
`define CSF_BIT_Z 1
`define CSF_BIT_C 0
`define CSF_STATUS_RESET 8'h00

// Register counts and pointer base registers.
`define CSF_NUM_REGS 32
`define CSF_PTR_X 5'h1A
`define CSF_PTR_Y 5'h1C
`define CSF_PTR_Z 5'h1E

// Data space layout.
`define CSF_IO_BASE 16'h0020
`define CSF_IO_LAST 16'h005F
`define CSF_IO_STATUS 6'h3F

// Register port addresses.
`define CSF_ADDR_STATUS 7'h5F
`define CSF_ADDR_CORE_STATE 7'h5E
`define CSF_ADDR_REG_LAST 7'h1F

// Interrupt vectors.
`define CSF_NUM_IRQ 8
`define CSF_VEC_STRIDE 16'h0002
`define CSF_RET_DEPTH 4
`define CSF_RESET_PC 16'h0000

`endif

// ### design/csf_pkg.sv
package csf_pkg;

    typedef enum logic [4:0] {
        OP_NOP  = 5'h00,
        OP_ADD  = 5'h01,
        OP_ADC  = 5'h02,
        OP_SUB  = 5'h03,
        OP_SBC  = 5'h04,
        OP_AND  = 5'h05,
        OP_OR   = 5'h06,
        OP_EOR  = 5'h07,
        OP_MOV  = 5'h08,
        OP_LDI  = 5'h09,
        OP_SUBI = 5'h0A,
        OP_SBCI = 5'h0B,
        OP_ANDI = 5'h0C,
        OP_ORI  = 5'h0D,
        OP_COM  = 5'h0E,
        OP_NEG  = 5'h0F,
        OP_INC  = 5'h10,
        OP_DEC  = 5'h11,
        OP_LSR  = 5'h12,
        OP_ROR  = 5'h13,
        OP_BST  = 5'h14,
        OP_BLD  = 5'h15,
        OP_SEI  = 5'h16,
        OP_CLI  = 5'h17,
        OP_IRQ_RETURN_INSTR = 5'h18,
        OP_LDP  = 5'h19,
        OP_STP  = 5'h1A,
        OP_LPM  = 5'h1B,
        OP_IN   = 5'h1C,
        OP_OUT  = 5'h1D,
        OP_RJMP = 5'h1E
    } csf_op_t;

    // One decoded instruction word from program memory.
    typedef struct packed {
        csf_op_t op;
        logic [4:0] rd;
        logic [4:0] rr;
        logic [7:0] imm;
        logic [2:0] bsel;
    } csf_instr_t;

    // ALU answer: result plus the flags and which of them the op writes.
    typedef struct packed {
        logic [7:0] res;
        logic h;
        logic v;
        logic n;
        logic z;
        logic c;
        logic [4:0] wmask;
        logic wr_reg;
    } csf_alu_t;

endpackage

// ### dv/csf_core_properties.sv
`timescale 1ns/1ps
module csf_core_properties
    import csf_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [15:0] pm_addr_o,
    input wire csf_instr_t pm_data_i,
    input wire logic [15:0] tbl_addr_o,
    input wire logic [7:0] irq_req_i,
    input wire logic irq_ack_o,
    input wire logic [2:0] irq_id_o,
    input wire logic [6:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o
);
    // One clock domain, so clocking and reset are given once for all properties.
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_ack_lowest_wins: assert property (
        irq_ack_o |-> irq_req_i[irq_id_o] && ((irq_req_i & ((8'h01 << irq_id_o) - 8'h01)) == 8'h00))
        else $error("interrupt taken while a higher priority request waits");
    a_ack_vector_jump: assert property (
        irq_ack_o |=> pm_addr_o == {12'h000, $past(irq_id_o), 1'b0} + 16'h0002)
        else $error("fetch did not move to the interrupt vector");
    a_ack_one_pulse: assert property (
        irq_ack_o |=> !irq_ack_o)
        else $error("interrupt acknowledged in two cycles running");
    a_reset_fetch: assert property (
        $fell(rst_i) |-> pm_addr_o == 16'h0000)
        else $error("fetch address not zero after reset");
    a_fetch_step: assert property (
        !irq_ack_o && !$past(rst_i) && $past(pm_data_i.op) != OP_IRQ_RETURN_INSTR
        && $past(pm_data_i.op) != OP_RJMP |=> pm_addr_o == $past(pm_addr_o) + 16'h0001)
        else $error("fetch address did not advance by one");
    // pointer low byte follows its register.
    a_ptr_low_byte: assert property (
        reg_wr_i && reg_addr_i == 7'h1E && $past(pm_data_i.op) == OP_NOP
        |=> tbl_addr_o[7:0] == $past(reg_wdata_i))
        else $error("table pointer low byte not updated");
    // pointer high byte follows its register.
    a_ptr_high_byte: assert property (
        reg_wr_i && reg_addr_i == 7'h1F && $past(pm_data_i.op) == OP_NOP
        |=> tbl_addr_o[15:8] == $past(reg_wdata_i))
        else $error("table pointer high byte not updated");
    // sign bit is N xor V.
    a_sign_bit_read: assert property (
        reg_rd_i && reg_addr_i == 7'h5F |=> reg_rdata_o[4] == (reg_rdata_o[2] ^ reg_rdata_o[3]))
        else $error("status sign bit differs from N xor V");
    // read data stands one cycle only.
    a_rdata_idle: assert property (
        !$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
        else $error("read data present without a read");

    // Main scenarios that the bench should reach.
    c_irq_taken: cover property (irq_ack_o);
    c_status_read: cover property (reg_rd_i && reg_addr_i == 7'h5F);
    c_reg_write: cover property (reg_wr_i);
endmodule

bind csf_core csf_core_properties i_csf_core_properties (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pm_addr_o(pm_addr_o),
    .pm_data_i(pm_data_i),
    .tbl_addr_o(tbl_addr_o),
    .irq_req_i(irq_req_i),
    .irq_ack_o(irq_ack_o),
    .irq_id_o(irq_id_o),
    .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o)
);

// ### dv/tb.sv
`timescale 1ns/1ps
module tb
    import csf_pkg::*;
();
    logic clk_i, rst_i, io_we_o, io_re_o, irq_ack_o, reg_wr_i, reg_rd_i;
    logic [15:0] pm_addr_o, tbl_addr_o;
    logic [7:0] tbl_data_i, io_wdata_o, io_rdata_i, irq_req_i, reg_wdata_i, reg_rdata_o;
    logic [5:0] io_addr_o;
    logic [2:0] irq_id_o;
    logic [6:0] reg_addr_i;
    csf_instr_t pm_data_i;
    csf_instr_t prog [0:255];
    int errors, total_checks;
    int io_wr = 0;
    int io_rd = 0;
    logic [13:0] io_seen;
    // ALU cases, run after a carry-setting add so unaffected flags show.
    csf_op_t al_op [0:5] = '{OP_ADD, OP_ADD, OP_SUB, OP_SUB, OP_SUB, OP_EOR};
    logic [7:0] al_a [0:5] = '{8'h7F, 8'hFF, 8'h05, 8'h00, 8'h80, 8'hAA};
    logic [7:0] al_b [0:5] = '{8'h01, 8'h01, 8'h05, 8'h01, 8'h01, 8'h2A};
    logic [7:0] al_res [0:5] = '{8'h80, 8'h00, 8'h00, 8'hFF, 8'h7F, 8'h80};
    logic [7:0] al_st [0:5] = '{8'h2C, 8'h23, 8'h02, 8'h35, 8'h38, 8'h35};

    // Memories answer combinationally; echoes keep the read paths busy.
    assign pm_data_i = prog[pm_addr_o[7:0]];
    assign tbl_data_i = tbl_addr_o[7:0];
    assign io_rdata_i = {2'h0, io_addr_o};

    // The I/O strobes are combinational, so their values before each edge are logged.
    always @(posedge clk_i)
    begin
        io_rd <= io_rd + int'(io_re_o === 1'b1);
        if (io_we_o === 1'b1)
        begin
            io_wr <= io_wr + 1;
            io_seen <= {io_addr_o, io_wdata_o};
        end
    end

    csf_core i_csf_core (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pm_addr_o(pm_addr_o),
        .pm_data_i(pm_data_i),
        .tbl_addr_o(tbl_addr_o),
        .tbl_data_i(tbl_data_i),
        .io_addr_o(io_addr_o),
        .io_wdata_o(io_wdata_o),
        .io_we_o(io_we_o),
        .io_re_o(io_re_o),
        .io_rdata_i(io_rdata_i),
        .irq_req_i(irq_req_i),
        .irq_ack_o(irq_ack_o),
        .irq_id_o(irq_id_o),
        .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o)
    );

    // A 5 ns clock.
    initial
    begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    // Instruction builders; NOP is the all-zero word.
    function automatic csf_instr_t li(logic [4:0] r, logic [7:0] v);
        return {OP_LDI, r, 5'h00, v, 3'h0};
    endfunction
    function automatic csf_instr_t op2(csf_op_t op, logic [4:0] rd, logic [4:0] rr, logic [2:0] b);
        return {op, rd, rr, 8'h00, b};
    endfunction

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Register port: strobes last one cycle, read data is taken the cycle after.
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        #1;
        d = reg_rdata_o;
    endtask

    task automatic rdc(input logic [6:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        chk({8'h00, d}, {8'h00, exp});
    endtask

    // Programs are rewritten only while reset holds the core.
    task automatic restart;
        @(posedge clk_i);
        rst_i <= 1'b1;
        irq_req_i <= 8'h00;
        cyc(2);
        #1;
        foreach (prog[i]) prog[i] = '0;
    endtask

    task automatic go;
        @(posedge clk_i);
        rst_i <= 1'b0;
    endtask

    // Main sequence.
    initial
    begin
        int n;
        int acks;
        logic [7:0] d;
        errors = 0;
        total_checks = 0;
        rst_i = 1'b1;
        irq_req_i = 8'h00;
        reg_addr_i = 7'h00;
        reg_wdata_i = 8'h00;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        foreach (prog[i]) prog[i] = '0;
        cyc(11);
        go;
        rdc(7'h5F, 8'h00);
        wr(7'h09, 8'hA5);
        rdc(7'h09, 8'hA5);
        rdc(7'h60, 8'h00);
        wr(7'h5F, 8'h10);
        rdc(7'h5F, 8'h00);
        wr(7'h5F, 8'h08);
        rdc(7'h5F, 8'h18);
        wr(7'h5F, 8'h0C);
        rdc(7'h5F, 8'h0C);
        wr(7'h1E, 8'h34);
        wr(7'h1F, 8'h12);
        #1;
        chk(tbl_addr_o, 16'h1234);
        $display("test register port done");
        // Flags each case writes must replace those of the preceding add.
        for (n = 0; n < 6; n++)
        begin
            restart;
            prog[0] = li(5'h04, 8'hFF);
            prog[1] = li(5'h05, 8'h01);
            prog[2] = op2(OP_ADD, 5'h04, 5'h05, 3'h0);
            prog[3] = li(5'h01, al_a[n]);
            prog[4] = li(5'h02, al_b[n]);
            prog[5] = op2(al_op[n], 5'h01, 5'h02, 3'h0);
            prog[6] = op2(OP_MOV, 5'h03, 5'h01, 3'h0);
            go;
            cyc(12);
            rdc(7'h5F, al_st[n]);
            rdc(7'h01, al_res[n]);
            rdc(7'h03, al_res[n]);
        end
        $display("test alu flags done");
        restart;
        prog[0] = li(5'h06, 8'h08);
        prog[1] = op2(OP_BST, 5'h06, 5'h00, 3'h3);
        prog[2] = li(5'h07, 8'h00);
        prog[3] = op2(OP_BLD, 5'h07, 5'h00, 3'h0);
        go;
        cyc(10);
        rdc(7'h5F, 8'h40);
        rdc(7'h07, 8'h01);
        $display("test bit copy done");
        restart;
        prog[0] = op2(OP_SEI, 5'h00, 5'h00, 3'h0);
        go;
        cyc(6);
        rdc(7'h5F, 8'h80);
        restart;
        prog[0] = op2(OP_SEI, 5'h00, 5'h00, 3'h0);
        prog[1] = op2(OP_CLI, 5'h00, 5'h00, 3'h0);
        go;
        cyc(6);
        rdc(7'h5F, 8'h00);
        // Requests must stay unanswered while the global enable is clear.
        @(posedge clk_i);
        irq_req_i <= 8'hFF;
        acks = 0;
        for (n = 0; n < 20; n++)
        begin
            @(posedge clk_i);
            #1;
            acks += (irq_ack_o === 1'b1);
        end
        chk(acks[15:0], 16'h0000);
        $display("test enable gating done");
        // Status also answers at I/O 0x3F; other I/O goes out on the strobes.
        restart;
        prog[0] = li(5'h01, 8'h21);
        prog[1] = {OP_OUT, 5'h01, 5'h00, 8'h3F, 3'h0};
        prog[2] = li(5'h02, 8'h5A);
        prog[3] = {OP_OUT, 5'h02, 5'h00, 8'h05, 3'h0};
        prog[4] = {OP_IN, 5'h03, 5'h00, 8'h12, 3'h0};
        prog[5] = li(5'h1A, 8'h25);
        prog[6] = li(5'h1B, 8'h00);
        prog[7] = op2(OP_LDP, 5'h04, 5'h00, 3'h0);
        go;
        cyc(12);
        rdc(7'h5F, 8'h21);
        rdc(7'h03, 8'h12);
        rdc(7'h04, 8'h05);
        chk(io_wr[15:0], 16'h0001);
        chk(io_rd[15:0], 16'h0002);
        chk({2'h0, io_seen}, 16'h055A);
        $display("test io space done");
        // The handler changes Z; the flags it leaves must survive the return.
        restart;
        prog[0] = li(5'h08, 8'h00);
        prog[1] = op2(OP_SEI, 5'h00, 5'h00, 3'h0);
        prog[14] = op2(OP_ADD, 5'h08, 5'h08, 3'h0);
        prog[15] = op2(OP_IRQ_RETURN_INSTR, 5'h00, 5'h00, 3'h0);
        go;
        irq_req_i <= 8'hC0;
        for (n = 0; n < 30 && irq_ack_o !== 1'b1; n++)
        begin
            @(posedge clk_i);
            #1;
        end
        if (n == 30)
        begin
            errors++;
            stop_test;
        end
        chk({13'h0000, irq_id_o}, 16'h0006);
        @(posedge clk_i);
        irq_req_i <= 8'h00;
        #1;
        chk(pm_addr_o, 16'h000E);
        rd(7'h5F, d);
        chk({8'h00, d & 8'h80}, 16'h0000);
        cyc(6);
        rdc(7'h5F, 8'h82);
        $display("test interrupt done");
        stop_test;
    end
endmodule
